// File: core/stc_defs.vh
// constants for the sensitivity temperature compensation block
`ifndef STC_DEFS_VH
`define STC_DEFS_VH
// register indices, byte address is four times the index
`define STC_IDX_CTRL     8'h00
`define STC_IDX_STATUS   8'h01
`define STC_IDX_FACTOR   8'h02
`define STC_IDX_TC2      8'h08
`define STC_IDX_TC1      8'h09
// word index sits in address bits 9:2
`define STC_IDX_HI       9
`define STC_IDX_LO       2
// first-order register fields
`define STC_TC1OFS_HI    7
`define STC_TC1OFS_LO    0
`define STC_TC1CLD_HI    15
`define STC_TC1CLD_LO    8
`define STC_TC1HOT_HI    23
`define STC_TC1HOT_LO    16
// second-order register fields
`define STC_TC2CLD_HI    14
`define STC_TC2CLD_LO    6
`define STC_TC2HOT_HI    23
`define STC_TC2HOT_LO    15
// writable bit masks, everything else reads zero
`define STC_TC1_MASK     32'h00FFFFFF
`define STC_TC2_MASK     32'h00FFFFC0
`define STC_CTRL_MASK    32'h00000001
`define STC_CTRL_RESET   32'h00000001
// first-order code wraps so that 1100 0000 is the lowest step
`define STC_TC1_BIAS     8'h40
`define STC_TC1_ZERO     10'sh040
// 25 degC in 1/8 degC temperature units
`define STC_T25          13'sh00C8
// gain factor: 2^30 is unity
`define STC_FRAC         30
`define STC_UNITY        40'sh0040000000
// 1.53e-5 per step per degC, over 8 (temp units), times 2^30
`define STC_K1           13'sh0806
// 5.96e-8 per step per degC^2, over 64, times 2^30 is one
`define STC_K2           1
// sample saturation limits
`define STC_SMAX         16'sh7FFF
`define STC_SMIN         16'sh8000
// bus answers
`define STC_RESP_OK      2'b00
`define STC_RESP_ERR     2'b10
`endif

// File: core/stc_gain_calc.v
// gain factor computation from temperature and coefficients
`timescale 1ns/1ps
`include "stc_defs.vh"
module stc_gain_calc (
   input  wire               sys_clk,
   input  wire               rst,
   input  wire               enable,
   input  wire        [23:0] tc1_reg,
   input  wire        [23:0] tc2_reg,
   input  wire               in_valid,
   input  wire signed [15:0] in_sample,
   input  wire signed [11:0] in_temp,
   output reg                out_valid,
   output reg  signed [15:0] out_sample,
   output reg  signed [39:0] factor,
   output reg         [1:0]  region
);
   reg                v1;        // stage-one valid
   reg  signed [15:0] s1;        // stage-one sample
   reg  signed [12:0] dt;        // temperature minus 25 degC
   reg         [7:0]  c1;        // chosen first-order code
   reg  signed [8:0]  c2;        // chosen second-order code
   reg                en1;       // enable aligned to stage one
   wire signed [12:0] next_dt;
   wire        [7:0]  u1;        // wrapped first-order code
   wire signed [9:0]  st1;       // first-order steps, -64..191
   wire signed [39:0] term1;
   wire signed [39:0] term2;

   assign next_dt = {in_temp[11], in_temp} - `STC_T25;
   // the wrap puts code 0 at zero steps, so cleared fields do nothing
   assign u1    = c1 + `STC_TC1_BIAS;
   assign st1   = $signed({2'b00, u1}) - `STC_TC1_ZERO;
   // linear term: steps times delta temperature
   assign term1 = st1 * dt * `STC_K1;
   // quadratic term: signed code times delta squared
   assign term2 = c2 * dt * dt * `STC_K2;

   // stage one: pick hot or cold coefficients from the sign of delta
   always @(posedge sys_clk) begin
      if (rst) begin
         v1  <= 1'b0;
         s1  <= 16'sh0000;
         dt  <= 13'sh0000;
         c1  <= 8'h00;
         c2  <= 9'sh000;
         en1 <= 1'b0;
      end else begin
         v1  <= in_valid;
         en1 <= enable;
         if (in_valid) begin
            s1 <= in_sample;
            dt <= next_dt;
            // at exactly 25 degC delta is zero and either pick gives unity
            if (next_dt > 13'sh0000) begin
               c1 <= tc1_reg[`STC_TC1HOT_HI:`STC_TC1HOT_LO];
               c2 <= tc2_reg[`STC_TC2HOT_HI:`STC_TC2HOT_LO];
            end else begin
               c1 <= tc1_reg[`STC_TC1CLD_HI:`STC_TC1CLD_LO];
               c2 <= tc2_reg[`STC_TC2CLD_HI:`STC_TC2CLD_LO];
            end
         end
      end
   end

   // stage two: combine both corrections into one factor
   always @(posedge sys_clk) begin
      if (rst) begin
         out_valid  <= 1'b0;
         out_sample <= 16'sh0000;
         factor     <= `STC_UNITY;
         region     <= 2'b00;
      end else begin
         out_valid <= v1;
         if (v1) begin
            out_sample <= s1;
            region     <= {dt < 13'sh0000, dt > 13'sh0000};
            // disabled compensation passes the sample at unity gain
            if (en1)
               factor <= `STC_UNITY + term1 + term2;
            else
               factor <= `STC_UNITY;
         end
      end
   end
endmodule // stc_gain_calc

// File: core/stc_top.v
// sensitivity temperature compensation with AXI4-Lite registers
//
// How it works
// - first-order cold/hot codes at 0x09 bits 15:8/23:16
// - linear correction, hot above 25C, cold below
// - first-order code wraps, 1.53 m%/C steps
// - second-order cold/hot at 0x08 bits 14:6/23:15
// - quadratic correction, hot above 25C, cold below
// - second-order code signed, 0.00596 m%/C^2 steps
// - 0x09 bits 7:0 hold offset coefficient
//
// data path: a sample with its temperature enters on in_valid and
// leaves corrected three clocks later on out_valid.
//
// register map, byte address is four times the word index:
//   word 0x00 control, bit 0 enables compensation, set after reset
//   word 0x01 status, bit 1 last sample cold, bit 0 last sample hot
//   word 0x02 gain factor, its upper 32 of 40 bits
//   word 0x08 second-order hot and cold codes
//   word 0x09 first-order hot and cold codes and the offset code
// any other word answers with a slave error and changes nothing.
//
// bus timing: a write is answered two clocks after its later half is
// taken, a read one clock after its address; one read may be open, and a second write may be taken while the first answer waits.
//
// the offset code is only stored and read back; offset drift is
// corrected elsewhere in the signal path.
//
// limitation: the factor follows the temperature that came with the
// sample, so a stale temperature gives a stale correction.
// trade-off: a 40-bit factor keeps the quadratic term exact at the
// extremes of the temperature range, at the cost of a wide multiply.
`timescale 1ns/1ps
`include "stc_defs.vh"
module stc_top (
   input  wire               sys_clk,
   input  wire               rst,
   // write address channel
   input  wire        [31:0] s_axi_awaddr,
   input  wire               s_axi_awvalid,
   output reg                s_axi_awready,
   // write data channel
   input  wire        [31:0] s_axi_wdata,
   input  wire        [3:0]  s_axi_wstrb,
   input  wire               s_axi_wvalid,
   output reg                s_axi_wready,
   // write response channel
   output reg         [1:0]  s_axi_bresp,
   output reg                s_axi_bvalid,
   input  wire               s_axi_bready,
   // read address channel
   input  wire        [31:0] s_axi_araddr,
   input  wire               s_axi_arvalid,
   output reg                s_axi_arready,
   // read data channel
   output reg         [31:0] s_axi_rdata,
   output reg         [1:0]  s_axi_rresp,
   output reg                s_axi_rvalid,
   input  wire               s_axi_rready,
   // sensed signal path and temperature measurement
   input  wire               in_valid,
   input  wire signed [15:0] in_sample,
   input  wire signed [11:0] in_temp,
   output reg                out_valid,
   output reg  signed [15:0] out_sample
);
   // register storage
   reg  [31:0] ctrl;             // bit 0 enables compensation
   reg  [31:0] tc1;              // first-order codes and offset code
   reg  [31:0] tc2;              // second-order codes
   // write side holding state
   reg  [31:0] aw_addr;          // captured write address
   reg  [31:0] w_data;           // captured write data
   reg  [3:0]  w_strb;           // captured byte enables
   reg         aw_full;          // address waiting
   reg         w_full;           // data waiting
   // combinational helpers
   reg  [31:0] next_tc1;
   reg  [31:0] next_tc2;
   reg  [31:0] next_ctrl;
   reg  [31:0] next_rdata;
   reg  [1:0]  next_rresp;
   reg         next_bad;         // write hit no register
   wire [7:0]  wr_idx;
   wire [7:0]  rd_idx;
   wire        do_write;
   // calculator outputs
   wire               calc_valid;
   wire signed [15:0] calc_sample;
   wire signed [39:0] calc_factor;
   wire        [1:0]  calc_region;
   wire signed [55:0] prod;      // sample times factor
   wire signed [25:0] scaled;    // product back at sample scale
   wire        [31:0] wmask;     // byte enables spread to bits
   wire signed [25:0] sat_hi;    // largest sample, widened to the width of scaled
   wire signed [25:0] sat_lo;    // smallest sample, widened to the width of scaled

   assign wr_idx   = aw_addr[`STC_IDX_HI:`STC_IDX_LO];
   assign rd_idx   = s_axi_araddr[`STC_IDX_HI:`STC_IDX_LO];
   // the response waits until both halves have arrived
   assign do_write = aw_full && w_full && !s_axi_bvalid;

   // one generate loop spreads each strobe over its byte
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb = gb + 1) begin : g_mask
         assign wmask[gb*8+7:gb*8] = {8{w_strb[gb]}};
      end
   endgenerate

   // address and data are taken in either order and held until used
   always @(posedge sys_clk) begin
      if (rst) begin
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
         aw_addr       <= 32'h00000000;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         // ready rises once the slot is empty, held low while full
         if (s_axi_awvalid && s_axi_awready) begin
            // address taken; refuse another until this write is done
            aw_full       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (do_write) begin
            // write applied this clock, the slot empties
            aw_full <= 1'b0;
         end else if (!aw_full) begin
            // empty slot is offered again one clock later
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            // data and strobes are taken together
            w_full       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (do_write) begin
            // data consumed by the write
            w_full <= 1'b0;
         end else if (!w_full) begin
            // ready again once the data slot is empty
            s_axi_wready <= 1'b1;
         end
      end
   end

   // merge strobed bytes into the addressed register
   always @* begin
      next_tc1  = tc1;
      next_tc2  = tc2;
      next_ctrl = ctrl;
      next_bad  = 1'b0;
      case (wr_idx)
         `STC_IDX_TC1: begin
            // offset coefficient rides beside the gain codes
            next_tc1 = ((tc1 & ~wmask) | (w_data & wmask)) & `STC_TC1_MASK;
         end
         `STC_IDX_TC2: begin
            // the low six bits are unused and stay zero
            next_tc2 = ((tc2 & ~wmask) | (w_data & wmask)) & `STC_TC2_MASK;
         end
         `STC_IDX_CTRL: begin
            // only the enable bit is writable
            next_ctrl = ((ctrl & ~wmask) | (w_data & wmask)) & `STC_CTRL_MASK;
         end
         `STC_IDX_STATUS,
         `STC_IDX_FACTOR: begin
            // read-only words ignore the write but answer okay
            next_bad = 1'b0;
         end
         default: begin
            // unmapped word: nothing changes, the answer is an error
            next_bad = 1'b1;
         end
      endcase
   end

   // register update and write response
   always @(posedge sys_clk) begin
      if (rst) begin
         // all-zero codes apply no correction until programmed
         tc1          <= 32'h00000000;
         tc2          <= 32'h00000000;
         ctrl         <= `STC_CTRL_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `STC_RESP_OK;
      end else begin
         if (do_write) begin
            // only the addressed word changes; the others reload themselves
            tc1          <= next_tc1;
            tc2          <= next_tc2;
            ctrl         <= next_ctrl;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= next_bad ? `STC_RESP_ERR : `STC_RESP_OK;
         end else if (s_axi_bvalid && s_axi_bready) begin
            // answer taken by the master
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read mux; status and factor show the block's live state
   always @* begin
      next_rdata = 32'h00000000;
      next_rresp = `STC_RESP_OK;
      case (rd_idx)
         `STC_IDX_CTRL: begin
            next_rdata = ctrl;
         end
         `STC_IDX_STATUS: begin
            // both bits clear after a sample at exactly 25 degC
            next_rdata = {30'h00000000, calc_region};
         end
         `STC_IDX_FACTOR: begin
            // upper bits only; the lowest eight are below resolution
            next_rdata = calc_factor[39:8];
         end
         `STC_IDX_TC1: begin
            next_rdata = tc1;
         end
         `STC_IDX_TC2: begin
            next_rdata = tc2;
         end
         default: begin
            // unmapped word: zero data and a slave error
            next_rresp = `STC_RESP_ERR;
         end
      endcase
   end

   // one read at a time; arready drops while the answer waits
   always @(posedge sys_clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `STC_RESP_OK;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            // data follow the address as it stands at the handshake
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
         end else if (s_axi_rvalid && s_axi_rready) begin
            // answer taken; arready returns on the next clock
            s_axi_rvalid <= 1'b0;
         end else if (!s_axi_rvalid) begin
            // idle: ready for the next address
            s_axi_arready <= 1'b1;
         end
      end
   end

   // factor computation, two pipeline stages
   // only the low 24 bits of each coefficient word carry fields
   stc_gain_calc u_calc (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .enable     (ctrl[0]),
      .tc1_reg    (tc1[23:0]),
      .tc2_reg    (tc2[23:0]),
      .in_valid   (in_valid),
      .in_sample  (in_sample),
      .in_temp    (in_temp),
      .out_valid  (calc_valid),
      .out_sample (calc_sample),
      .factor     (calc_factor),
      .region     (calc_region)
   );

   // the gain correction is a multiply, not an offset add
   assign prod   = calc_sample * calc_factor;
   assign scaled = prod[`STC_FRAC+25:`STC_FRAC];

   // saturation limits at sample scale, widened to the rescaled product's width
   assign sat_hi = {{10{1'b0}}, `STC_SMAX};
   assign sat_lo = {{10{1'b1}}, `STC_SMIN};

   // final stage: rescale and saturate to the sample width
   always @(posedge sys_clk) begin
      if (rst) begin
         out_valid  <= 1'b0;
         out_sample <= 16'sh0000;
      end else begin
         out_valid <= calc_valid;
         if (calc_valid) begin
            // clipping keeps a large positive factor from wrapping sign
            if (scaled > sat_hi)
               out_sample <= `STC_SMAX;
            else if (scaled < sat_lo)
               out_sample <= `STC_SMIN;
            else
               out_sample <= scaled[15:0];
         end
      end
   end
endmodule // stc_top

// File: sim/stc_top_checker.sv
// port-level assertions for the compensation block
`timescale 1ns/1ps
`include "stc_defs.vh"
module stc_top_checker (
   input wire               sys_clk,
   input wire               rst,
   input wire               s_axi_awvalid,
   input wire               s_axi_awready,
   input wire               s_axi_wvalid,
   input wire               s_axi_wready,
   input wire        [1:0]  s_axi_bresp,
   input wire               s_axi_bvalid,
   input wire               s_axi_bready,
   input wire        [31:0] s_axi_araddr,
   input wire               s_axi_arvalid,
   input wire               s_axi_arready,
   input wire        [31:0] s_axi_rdata,
   input wire        [1:0]  s_axi_rresp,
   input wire               s_axi_rvalid,
   input wire               s_axi_rready,
   input wire               in_valid,
   input wire signed [15:0] in_sample,
   input wire signed [11:0] in_temp,
   input wire               out_valid,
   input wire signed [15:0] out_sample
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // read index that decodes to a register
   wire mapped = s_axi_araddr[9:2] inside {`STC_IDX_CTRL, `STC_IDX_STATUS, `STC_IDX_FACTOR,
                                           `STC_IDX_TC2, `STC_IDX_TC1};
   // both write halves taken together with no answer pending
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
   endsequence
   // read address taken
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // a sample taken exactly at the reference temperature
   sequence s_at_ref;
      in_valid && (in_temp == `STC_T25);
   endsequence
   chk_wr_answer: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
      else $error("write answer late or address still accepted");
   chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late or address still accepted");
   chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer not released");
   chk_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer not released");
   chk_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while answer pends");
   chk_bad_index: assert property (s_axi_arvalid && s_axi_arready && !mapped
      |=> s_axi_rresp == `STC_RESP_ERR && s_axi_rdata == 32'h00000000)
      else $error("unmapped read not refused");
   chk_out_latency: assert property (in_valid |-> ##3 out_valid)
      else $error("corrected sample not three cycles after input");
   chk_out_cause: assert property (out_valid |-> $past(in_valid, 3))
      else $error("corrected sample without an input");
   chk_ref_unity: assert property (s_at_ref |-> ##3 out_sample == $past(in_sample, 3))
      else $error("gain not unity at reference temperature");
   chk_sample_hold: assert property (!out_valid && !$past(rst) |-> $stable(out_sample))
      else $error("output sample moved without a new sample");
endmodule // stc_top_checker
bind stc_top stc_top_checker chk (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_valid,
   .in_sample, .in_temp, .out_valid, .out_sample);

// File: sim/stc_sensor_model.sv
// behavioural model of the sensing element and temperature path
`timescale 1ns/1ps
module stc_sensor_model (
   input  wire               sys_clk,
   output reg                in_valid,
   output reg  signed [15:0] in_sample,
   output reg  signed [11:0] in_temp
);
   // idle at time zero
   initial begin
      in_valid  = 1'b0;
      in_sample = 16'h0000;
      in_temp   = 12'h000;
   end
   // one sample per clock; after the last one the lines are scrambled
   // so a stale value can never pass for a fresh one
   task automatic send(input [15:0] s, input [11:0] t, input bit last);
      in_valid  <= 1'b1;
      in_sample <= s;
      in_temp   <= t;
      @(posedge sys_clk);
      if (last) begin
         in_valid  <= 1'b0;
         in_sample <= ~s;
         in_temp   <= ~t;
      end
   endtask
endmodule // stc_sensor_model

// File: sim/stc_top_tb.sv
// self-checking bench for the compensation block
`timescale 1ns/1ps
`include "stc_defs.vh"
`define CMP(n, e, a) begin exp_v = e; checks++; if (exp_v !== (a)) begin mismatches++; \
   $display("mismatch %s exp %h got %h", n, exp_v, a); end end
module stc_top_tb;
   reg                sys_clk;
   reg                rst;
   reg         [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, rnd;
   reg         [3:0]  s_axi_wstrb;
   reg                s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   wire               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire        [1:0]  s_axi_bresp, s_axi_rresp;
   wire        [31:0] s_axi_rdata;
   wire               in_valid, out_valid;
   wire signed [15:0] in_sample, out_sample;
   wire signed [11:0] in_temp;
   int                mismatches, checks;
   reg         [33:0] exp_v;          // expected value under comparison
   reg         [1:0]  exp_b[$];       // pending write responses
   reg         [33:0] exp_r[$];       // pending {rresp, rdata}
   reg         [15:0] exp_o[$];       // pending corrected samples
   longint            f;
   int                tl[5] = '{280, 120, 201, 199, 2047};
   localparam  [31:0] a_ctrl = {22'h0, `STC_IDX_CTRL, 2'b00};
   localparam  [31:0] a_sts = {22'h0, `STC_IDX_STATUS, 2'b00};
   localparam  [31:0] a_fac = {22'h0, `STC_IDX_FACTOR, 2'b00};
   localparam  [31:0] a_tc2 = {22'h0, `STC_IDX_TC2, 2'b00};
   localparam  [31:0] a_tc1 = {22'h0, `STC_IDX_TC1, 2'b00};
   stc_top DUT (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .in_valid, .in_sample, .in_temp, .out_valid, .out_sample);
   stc_sensor_model PM (.sys_clk, .in_valid, .in_sample, .in_temp);
   // 200 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   function automatic [31:0] lfsr(input [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // expected gain, 2^30 is unity; first-order code wraps by 0x40
   function automatic longint fac(input [23:0] t1, input [23:0] t2, input int t);
      int d;
      int s1;
      int c2;
      d = t - 200;
      s1 = (d > 0) ? t1[23:16] : t1[15:8];
      s1 = ((s1 + 64) % 256) - 64;
      c2 = (d > 0) ? $signed(t2[23:15]) : $signed(t2[14:6]);
      fac = (longint'(1) << 30) + longint'(s1) * d * 2054 + longint'(c2) * d * d;
   endfunction
   // one write; valids drop as each half is taken
   task automatic wr(input [31:0] a, input [31:0] d, input [1:0] r);
      exp_b.push_back(r);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   // one read; the monitor compares the answer
   task automatic rd(input [31:0] a, input [31:0] d, input [1:0] r);
      exp_r.push_back({r, d});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic smp(input [15:0] s, input [11:0] t, input [15:0] e, input bit last);
      exp_o.push_back(e);
      PM.send(s, t, last);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // monitor: oldest note against each answer as it appears
   always @(posedge sys_clk) begin
      if (s_axi_bvalid && s_axi_bready) `CMP("bresp", exp_b.pop_front(), s_axi_bresp)
      if (s_axi_rvalid && s_axi_rready) `CMP("rdata", exp_r.pop_front(), {s_axi_rresp, s_axi_rdata})
      if (out_valid) `CMP("out_sample", exp_o.pop_front(), out_sample)
   end
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      results;
   end
   initial begin
      rst = 1'b1;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_wstrb = 4'hF;
      rnd = 32'h093D;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd(a_ctrl, `STC_CTRL_RESET, `STC_RESP_OK);
      rd(a_tc1, 32'h00000000, `STC_RESP_OK);
      rd(a_tc2, 32'h00000000, `STC_RESP_OK);
      wr(a_fac, rnd, `STC_RESP_OK);
      rd(a_fac, 32'h00400000, `STC_RESP_OK);
      wr(32'h0000000C, rnd, `STC_RESP_ERR);
      rd(32'h0000000C, 32'h00000000, `STC_RESP_ERR);
      // random patterns come back through the writable masks
      repeat (3) begin
         rnd = lfsr(rnd);
         wr(a_tc1, rnd, `STC_RESP_OK);
         rd(a_tc1, rnd & `STC_TC1_MASK, `STC_RESP_OK);
         wr(a_tc2, ~rnd, `STC_RESP_OK);
         rd(a_tc2, ~rnd & `STC_TC2_MASK, `STC_RESP_OK);
      end
      // back-to-back samples at 25 degC with nonzero codes pass unchanged
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         smp(rnd[15:0], 12'h0C8, rnd[15:0], i == 5);
      end
      // extreme codes of both orders, hot and cold sides
      wr(a_tc1, 32'h00BFC000, `STC_RESP_OK);
      wr(a_tc2, {8'h00, 9'h0FF, 9'h100, 6'h00}, `STC_RESP_OK);
      foreach (tl[i]) begin
         smp(16'h0000, tl[i][11:0], 16'h0000, 1'b1);
         repeat (4) @(posedge sys_clk);
         f = fac(24'hBFC000, {9'h0FF, 9'h100, 6'h00}, tl[i]);
         rd(a_fac, f[39:8], `STC_RESP_OK);
         rd(a_sts, {30'h0, tl[i] < 200, tl[i] > 200}, `STC_RESP_OK);
      end
      smp(16'h7FFF, 12'h7FF, 16'h7FFF, 1'b0);
      smp(16'h8000, 12'h7FF, 16'h8000, 1'b1);
      // compensation switched off: unity gain despite extreme codes when hot
      wr(a_ctrl, 32'hFFFFFFFE, `STC_RESP_OK);
      rd(a_ctrl, 32'h00000000, `STC_RESP_OK);
      smp(16'h1234, 12'h7FF, 16'h1234, 1'b1);
      wr(a_ctrl, `STC_CTRL_RESET, `STC_RESP_OK);
      rd(a_fac, 32'h00400000, `STC_RESP_OK);
      // zeroed pairs give no correction at any temperature
      wr(a_tc1, 32'h00000000, `STC_RESP_OK);
      wr(a_tc2, 32'h00000000, `STC_RESP_OK);
      rnd = lfsr(rnd);
      smp(rnd[15:0], 12'h7FF, rnd[15:0], 1'b0);
      smp(rnd[31:16], 12'h800, rnd[31:16], 1'b1);
      repeat (8) @(posedge sys_clk);
      results;
   end
endmodule // stc_top_tb
